// ===== core/esr_pkg.sv
// Summary of operation
// R1: Interrupt route latches low until cleared.
// R2: Reset route pulses, rechecks while input low.
// R3: Reset plus watchdog route pulses once only; with wdo_latch_cfg low it pulses again after each watchdog release.
// R4: Watchdog route asserts fault until cleared.
// R5: Watchdog output needs enable pin high.
// R6: Reset pulse lasts configured reset delay.
// R7: Active only after load, and after self test when one runs.
// R8: Fatal faults enter the safe lock state.
// R9: Safe lock holds reset and interrupt low.
// R10: Operating state readable as monitor status.
// R11: Power-on self test only when bit set.
// R12: Configuration load corrects single, flags double.
// R13: Self test ignores pins, disables I2C.
// R14: Pass enables I2C, then load, active.
// R15: Failure drives pins low, I2C kept.
// R16: Self test reported in four places.
// R17: Trigger bit starts self test in operation.
// R18: Sequence timeout masks undervoltage after supply rise.
// R19: Completion sets done flag, optional interrupt.
// R20: Error delay code maps to milliseconds.
// R21: Low error input sets vendor flag.
// R22: Watchdog fault latches or releases by option.
// R23: Error input synchronised, delay restarts on high.
package esr_pkg;

  localparam int TICK_TIME_US = 1000;
  localparam int CLK_MHZ      = 100;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

  localparam int DLY_W  = 10;
  localparam int CODE_W = 8;

  localparam logic [CODE_W-1:0] SEG1_START = 8'h20;
  localparam logic [CODE_W-1:0] SEG2_START = 8'h40;
  localparam logic [DLY_W-1:0]  SEG0_ADD   = 10'h001;
  localparam logic [DLY_W-1:0]  SEG1_SUB   = 10'h01E;
  localparam logic [DLY_W-1:0]  SEG2_SUB   = 10'h09C;

  localparam logic [7:0] MON_STATUS_ADDR = 8'h30;
  localparam logic [7:0] CFG_TRIG_ADDR   = 8'h9F;

  localparam int MAP_IRQ = 0;
  localparam int MAP_RST = 1;
  localparam int MAP_WDO = 2;

  localparam int TIE_DONE = 0;
  localparam int TIE_FAIL = 1;

  localparam int CW_W      = 13;
  localparam int CFG_WORDS = 4;
  localparam int CFG_AW    = 2;
  localparam logic [CFG_AW-1:0] CFG_LAST = 2'h3;

  typedef enum logic [2:0] {
    MD_OFF      = 3'b000,
    MD_SELFTEST = 3'b001,
    MD_LOAD     = 3'b010,
    MD_ACTIVE   = 3'b011,
    MD_SAFE     = 3'b100
  } esr_mode_t;

  typedef enum logic [1:0] {
    ES_IDLE = 2'b00,
    ES_RST  = 2'b01,
    ES_HOLD = 2'b10
  } esr_esm_t;

  // One byte code to milliseconds [R20]
  function automatic logic [DLY_W-1:0] dly_ms(input logic [CODE_W-1:0] code);
    logic [DLY_W-1:0] c;
    c = {2'h0, code};
    if (code < SEG1_START) begin
      dly_ms = c + SEG0_ADD;
    end else if (code < SEG2_START) begin
      dly_ms = (c << 1) - SEG1_SUB;
    end else begin
      dly_ms = (c << 2) - SEG2_SUB;
    end
  endfunction

endpackage

// ===== core/esr_timer.sv
`timescale 1ns/1ps
module esr_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Millisecond enable
  input wire logic tick,
  // Control
  esr_tmr_if.tmr   t
);
  logic [esr_pkg::DLY_W-1:0] cnt_q;

  // Saturates so expiry stays a level until restart
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (t.restart) begin
      cnt_q <= '0;
    end else if (tick && !t.expired) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  assign t.expired = (cnt_q >= t.target);
endmodule

// ===== core/esr_tmr_if.sv
`timescale 1ns/1ps
interface esr_tmr_if;
  logic                     restart;
  logic [esr_pkg::DLY_W-1:0] target;
  logic                     expired;

  modport ctl (output restart, output target, input expired);
  modport tmr (input restart, input target, output expired);
endinterface

// ===== core/esr_top.sv
`timescale 1ns/1ps
module esr_top #(
  parameter int TICK_CYCLES = esr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Soc error input and watchdog enable
  input  wire logic                        soc_error_input_n,
  input  wire logic                        watchdog_enable_pin,
  // Routing and delay configuration
  input  wire logic [2:0]                  esm_map,
  input  wire logic [esr_pkg::CODE_W-1:0]  error_delay_code,
  input  wire logic [esr_pkg::CODE_W-1:0]  reset_pulse_delay,
  input  wire logic                        wdo_latch_cfg,
  input  wire logic [esr_pkg::CODE_W-1:0]  wdo_delay_code,
  input  wire logic [esr_pkg::CODE_W-1:0]  seq_timeout_code,
  // Host clear strobes and trigger
  input  wire logic                        error_flag_clr,
  input  wire logic                        test_flag_clr,
  input  wire logic                        selftest_trigger,
  input  wire logic [1:0]                  test_irq_enable,
  // Self test engine
  input  wire logic                        selftest_at_poweron,
  input  wire logic                        selftest_complete,
  input  wire logic                        selftest_fail,
  input  wire logic [3:0]                  selftest_result,
  output logic                             selftest_run,
  // Configuration store
  output logic                             otp_rd,
  output logic [esr_pkg::CFG_AW-1:0]       otp_addr,
  input  wire logic                        otp_valid,
  input  wire logic [esr_pkg::CW_W-1:0]    otp_data,
  output logic [8*esr_pkg::CFG_WORDS-1:0]  cfg_data,
  // Supply and faults
  input  wire logic                        supply_ok,
  input  wire logic                        uv_fault_raw,
  input  wire logic                        thermal_shutdown,
  input  wire logic                        addr_pin_fault,
  output logic                             uv_fault,
  // Open-drain pins
  output logic                             reset_output_n,
  output logic                             reset_output_oe,
  output logic                             interrupt_output_n,
  output logic                             interrupt_output_oe,
  output logic                             watchdog_fault_output_n,
  output logic                             watchdog_fault_output_oe,
  // Status
  output logic [2:0]                       monitor_status,
  output logic                             selftest_done_status,
  output logic                             selftest_done_flag,
  output logic                             selftest_fail_flag,
  output logic [3:0]                       selftest_info,
  output logic                             soc_error_flag,
  output logic                             esm_fault_flag,
  output logic                             ecc_corrected,
  output logic                             i2c_enable,
  output logic                             monitor_enable
);
  esr_pkg::esr_mode_t mode_q, mode_d;
  esr_pkg::esr_esm_t  es_q, es_d;

  // Millisecond enable divider
  logic [31:0] div_q;
  logic        tick;
  assign tick = (div_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) div_q <= '0;
    else     div_q <= tick ? '0 : div_q + 32'h1;
  end

  esr_tmr_if tmr_e ();
  esr_tmr_if tmr_w ();
  esr_tmr_if tmr_s ();
  esr_timer u_tmr_e (.core_clk(core_clk), .rst(rst), .tick(tick), .t(tmr_e));
  esr_timer u_tmr_w (.core_clk(core_clk), .rst(rst), .tick(tick), .t(tmr_w));
  esr_timer u_tmr_s (.core_clk(core_clk), .rst(rst), .tick(tick), .t(tmr_s));

  // SEC-DED over 8 data bits, position-coded Hamming with overall parity in bit 0
  logic [3:0] syn;
  logic       par_err, sec_err, ded_err;
  logic [7:0] dec_byte;
  logic [esr_pkg::CW_W-1:0] fixed_cw;
  always_comb begin
    syn = 4'h0;
    for (int i = 1; i < esr_pkg::CW_W; i++) begin
      if (otp_data[i]) syn = syn ^ 4'(i);
    end
    fixed_cw = otp_data;
    if (syn != 4'h0 && ^otp_data) fixed_cw[syn] = ~otp_data[syn];
  end
  assign par_err  = ^otp_data;
  assign sec_err  = par_err;                         // [R12]
  assign ded_err  = !par_err && (syn != 4'h0);       // [R12]
  assign dec_byte = {fixed_cw[12:9], fixed_cw[7:5], fixed_cw[3]};

  // Mode sequencer
  logic fatal_pin, load_ok, load_last;
  assign fatal_pin = thermal_shutdown || addr_pin_fault;
  assign load_ok   = otp_valid && !ded_err;
  assign load_last = load_ok && (otp_addr == esr_pkg::CFG_LAST);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      esr_pkg::MD_OFF:
        mode_d = selftest_at_poweron ? esr_pkg::MD_SELFTEST : esr_pkg::MD_LOAD; // [R11]
      esr_pkg::MD_SELFTEST: begin
        if (selftest_fail)          mode_d = esr_pkg::MD_SAFE;                  // [R15]
        else if (selftest_complete) mode_d = esr_pkg::MD_LOAD;                  // [R14]
      end
      esr_pkg::MD_LOAD: begin
        if (otp_valid && ded_err) mode_d = esr_pkg::MD_SAFE;                    // [R8]
        else if (load_last)       mode_d = esr_pkg::MD_ACTIVE;                  // [R7]
      end
      esr_pkg::MD_ACTIVE:
        if (selftest_trigger) mode_d = esr_pkg::MD_SELFTEST;                    // [R17]
      esr_pkg::MD_SAFE:
        mode_d = esr_pkg::MD_SAFE;                                              // [R9]
      default:
        mode_d = esr_pkg::MD_SAFE;
    endcase
    if (fatal_pin && mode_q != esr_pkg::MD_OFF) mode_d = esr_pkg::MD_SAFE;      // [R8]
  end

  // Strap is read by the clocked step out of OFF, never by the reset itself
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) mode_q <= esr_pkg::MD_OFF;
    else     mode_q <= mode_d;
  end

  logic active, in_test;
  assign active       = (mode_q == esr_pkg::MD_ACTIVE);
  assign in_test      = (mode_q == esr_pkg::MD_SELFTEST);
  assign selftest_run = in_test;
  assign otp_rd       = (mode_q == esr_pkg::MD_LOAD);
  assign monitor_status = mode_q;                                               // [R10]
  assign monitor_enable = active;                                               // [R7]
  assign i2c_enable     = !in_test && (mode_q != esr_pkg::MD_OFF);              // [R13] [R14]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      otp_addr      <= '0;
      cfg_data      <= '0;
      ecc_corrected <= 1'b0;
    end else if (otp_rd && load_ok) begin
      otp_addr              <= otp_addr + 2'h1;
      cfg_data[otp_addr*8 +: 8] <= dec_byte;                                    // [R12]
      if (sec_err) ecc_corrected <= 1'b1;
    end
  end

  // Self test reporting, set wins over clear
  logic st_end;
  assign st_end = in_test && (selftest_complete || selftest_fail);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selftest_done_flag   <= 1'b0;
      selftest_fail_flag   <= 1'b0;
      selftest_done_status <= 1'b0;
      selftest_info        <= 4'h0;
    end else begin
      if (st_end)             selftest_done_flag <= 1'b1;                       // [R19]
      else if (test_flag_clr) selftest_done_flag <= 1'b0;
      if (in_test && selftest_fail) selftest_fail_flag <= 1'b1;                 // [R16]
      else if (test_flag_clr)       selftest_fail_flag <= 1'b0;
      if (st_end) selftest_done_status <= 1'b1;                                 // [R16]
      else if (mode_d == esr_pkg::MD_SELFTEST && !in_test) selftest_done_status <= 1'b0;
      if (st_end) selftest_info <= selftest_result;                             // [R16]
    end
  end

  // Error input synchroniser, ignored outside ACTIVE
  logic sync1_q, sync2_q, err_low;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= soc_error_input_n;                                             // [R23]
      sync2_q <= sync1_q;
    end
  end
  assign err_low = !sync2_q && active;                                          // [R13]

  // Routing decode
  logic r_irq, r_rst, r_wdo, wdo_q, irq_latch_q, hit, rst_blocked;
  assign r_irq       = esm_map[esr_pkg::MAP_IRQ];
  assign r_rst       = esm_map[esr_pkg::MAP_RST];
  assign r_wdo       = esm_map[esr_pkg::MAP_WDO] && watchdog_enable_pin;        // [R5]
  assign hit         = (es_q == esr_pkg::ES_IDLE) && err_low && tmr_e.expired;  // [R23]
  assign rst_blocked = r_wdo && wdo_q;                                          // [R3]

  always_comb begin
    es_d = es_q;
    case (es_q)
      esr_pkg::ES_IDLE:
        if (hit && r_rst && !rst_blocked) es_d = esr_pkg::ES_RST;               // [R2]
      esr_pkg::ES_RST:
        if (tmr_e.expired) es_d = (r_wdo && wdo_q) ? esr_pkg::ES_HOLD : esr_pkg::ES_IDLE; // [R6]
      esr_pkg::ES_HOLD:
        if (!(r_wdo && wdo_q)) es_d = esr_pkg::ES_IDLE;                         // [R3]
      default:
        es_d = esr_pkg::ES_IDLE;
    endcase
    if (!active) es_d = esr_pkg::ES_IDLE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) es_q <= esr_pkg::ES_IDLE;
    else     es_q <= es_d;
  end

  // Delay restarts on every phase change, on a hit, and while idle with the input high
  assign tmr_e.restart = (es_d != es_q) || hit ||
                         ((es_q == esr_pkg::ES_IDLE) && !err_low);              // [R23] [R2]
  assign tmr_e.target  = (es_q == esr_pkg::ES_RST) ?
                         esr_pkg::dly_ms(reset_pulse_delay) :                   // [R6]
                         esr_pkg::dly_ms(error_delay_code);                     // [R20]

  assign tmr_w.restart = !wdo_q;
  assign tmr_w.target  = esr_pkg::dly_ms(wdo_delay_code);

  // Latched fault state; a new event beats a same-cycle clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_latch_q    <= 1'b0;
      wdo_q          <= 1'b0;
      esm_fault_flag <= 1'b0;
      soc_error_flag <= 1'b0;
    end else begin
      if (hit && r_irq)        irq_latch_q <= 1'b1;                             // [R1] [R22]
      else if (error_flag_clr) irq_latch_q <= 1'b0;
      if (hit && r_wdo) wdo_q <= 1'b1;                                          // [R4]
      else if (error_flag_clr || !watchdog_enable_pin ||
               (!wdo_latch_cfg && tmr_w.expired)) wdo_q <= 1'b0;                // [R22] [R5]
      if (hit && (r_irq || r_wdo)) esm_fault_flag <= 1'b1;                      // [R1] [R4]
      else if (error_flag_clr)     esm_fault_flag <= 1'b0;
      if (err_low)             soc_error_flag <= 1'b1;                          // [R21]
      else if (error_flag_clr) soc_error_flag <= 1'b0;
    end
  end

  // Sequence timeout after supply rise masks undervoltage
  assign tmr_s.restart = !supply_ok;                                            // [R18]
  assign tmr_s.target  = esr_pkg::dly_ms(seq_timeout_code);

  logic safe, irq_req, rst_req;
  assign safe    = (mode_q == esr_pkg::MD_SAFE);
  assign irq_req = safe || irq_latch_q ||                                       // [R9] [R15]
                   (selftest_done_flag && test_irq_enable[esr_pkg::TIE_DONE]) ||// [R19]
                   (selftest_fail_flag && test_irq_enable[esr_pkg::TIE_FAIL]);  // [R16]
  assign rst_req = safe || (es_q == esr_pkg::ES_RST);                           // [R9] [R2]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_output_n          <= 1'b1;
      interrupt_output_n      <= 1'b1;
      watchdog_fault_output_n <= 1'b1;
      uv_fault                <= 1'b0;
    end else begin
      reset_output_n          <= !rst_req;
      interrupt_output_n      <= !irq_req;
      watchdog_fault_output_n <= !(wdo_q && watchdog_enable_pin);               // [R5]
      uv_fault                <= uv_fault_raw && active && tmr_s.expired;       // [R18]
    end
  end
  assign reset_output_oe          = !reset_output_n;
  assign interrupt_output_oe      = !interrupt_output_n;
  assign watchdog_fault_output_oe = !watchdog_fault_output_n;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence ded_seen_s;
    (mode_q == esr_pkg::MD_LOAD) && otp_valid && ded_err;
  endsequence
  sequence safe_pins_s;
    !reset_output_n && !interrupt_output_n;
  endsequence

  safe_pins_a: assert property (safe |=> safe_pins_s) // [R9]
    else $error("Safe lock did not hold pins low");
  safe_stays_a: assert property (safe |=> safe) // [R9]
    else $error("Safe lock state was left");
  ded_safe_a: assert property (ded_seen_s |=> safe ##1 safe_pins_s) // [R8]
    else $error("Double error did not lock");
  wdo_gate_a: assert property (!watchdog_enable_pin |=> watchdog_fault_output_n) // [R5]
    else $error("Watchdog fault asserted with enable low");
  irq_hold_a: assert property (irq_latch_q && !error_flag_clr |=> irq_latch_q) // [R1]
    else $error("Interrupt latch dropped without clear");
  test_quiet_a: assert property (in_test |-> !i2c_enable && !hit) // [R13]
    else $error("Activity during self test");
  por_skip_a: assert property (mode_q == esr_pkg::MD_OFF && !selftest_at_poweron
                               |=> mode_q == esr_pkg::MD_LOAD) // [R11]
    else $error("Self test run without power-on bit");
  rst_len_a: assert property (es_q == esr_pkg::ES_RST && !tmr_e.expired && active
                              |=> es_q == esr_pkg::ES_RST ##1 !reset_output_n) // [R6]
    else $error("Reset pulse ended early");
  uv_mask_a: assert property (!tmr_s.expired |=> !uv_fault) // [R18]
    else $error("Undervoltage not masked");
  done_irq_a: assert property (st_end && test_irq_enable[esr_pkg::TIE_DONE]
                               && !test_flag_clr |=> ##1 !interrupt_output_n) // [R19]
    else $error("Done interrupt missing");
endmodule

// ===== tb/esr_far_model.sv
`timescale 1ns/1ps
module esr_far_model (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Configuration store
  input  wire logic                       otp_rd,
  input  wire logic [esr_pkg::CFG_AW-1:0] otp_addr,
  output logic                            otp_valid,
  output logic [esr_pkg::CW_W-1:0]        otp_data,
  // Test engine
  input  wire logic                       selftest_run,
  output logic                            selftest_complete,
  output logic                            selftest_fail,
  output logic [3:0]                      selftest_result,
  // Bench control
  input  wire logic [31:0]                cfg_words,
  input  wire logic [1:0]                 err_mode,
  input  wire logic                       slow,
  input  wire logic                       st_bad,
  input  wire logic [3:0]                 st_res
);
  logic [12:0] word_c;
  logic [12:0] flip_c;
  logic        ph_q;
  logic [3:0]  cnt_q;

  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] c;
    c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 3'b000};
    for (int p = 1; p < 9; p = p * 2) begin
      for (int i = 3; i < 13; i++) begin
        if ((i & p) != 0 && (i & (i - 1)) != 0) c[p] = c[p] ^ c[i];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction

  assign word_c = enc(cfg_words[8*otp_addr +: 8]);
  assign flip_c = (err_mode == 2'h1 && otp_addr == 2'h1) ? 13'h0020 :
                  (err_mode == 2'h2 && otp_addr == 2'h2) ? 13'h0220 : 13'h0000;
  // Slow store answers every other cycle only
  assign otp_valid = otp_rd && (!slow || ph_q);
  // Not valid: show the inverse so stale data never looks good
  assign otp_data = otp_valid ? (word_c ^ flip_c) : ~word_c;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_q  <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      ph_q  <= !ph_q;
      cnt_q <= !selftest_run ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
    end
  end

  assign selftest_complete = selftest_run && cnt_q == 4'h8 && !st_bad;
  assign selftest_fail     = selftest_run && cnt_q == 4'h8 && st_bad;
  assign selftest_result   = st_res;
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin \
  compares++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
  end \
end
module tb;
  localparam int TC = 4;
  logic        core_clk, rst, soc_error_input_n, watchdog_enable_pin, wdo_latch_cfg;
  logic        error_flag_clr, test_flag_clr, selftest_trigger, selftest_at_poweron;
  logic        selftest_complete, selftest_fail, selftest_run, otp_rd, otp_valid;
  logic        supply_ok, uv_fault_raw, thermal_shutdown, addr_pin_fault, uv_fault;
  logic        reset_output_n, reset_output_oe, interrupt_output_n, interrupt_output_oe;
  logic        watchdog_fault_output_n, watchdog_fault_output_oe, selftest_done_status;
  logic        selftest_done_flag, selftest_fail_flag, soc_error_flag, esm_fault_flag;
  logic        ecc_corrected, i2c_enable, monitor_enable, slow, st_bad, mon_on;
  logic [2:0]  esm_map, monitor_status;
  logic [7:0]  error_delay_code, reset_pulse_delay, wdo_delay_code, seq_timeout_code;
  logic [1:0]  test_irq_enable, otp_addr, err_mode;
  logic [3:0]  selftest_result, selftest_info, st_res;
  logic [12:0] otp_data;
  logic [31:0] cfg_data, cfg_words;
  logic [7:0]  codes [4] = '{8'h1F, 8'h20, 8'h40, 8'hFF};
  int          seed = 32'h836C, mismatches = 0, compares = 0, run = 0, npulse, n, k;

  esr_top #(.TICK_CYCLES(TC)) esr_top_i (.core_clk, .rst, .soc_error_input_n,
    .watchdog_enable_pin, .esm_map, .error_delay_code, .reset_pulse_delay, .wdo_latch_cfg,
    .wdo_delay_code, .seq_timeout_code, .error_flag_clr, .test_flag_clr, .selftest_trigger,
    .test_irq_enable, .selftest_at_poweron, .selftest_complete, .selftest_fail,
    .selftest_result, .selftest_run, .otp_rd, .otp_addr, .otp_valid, .otp_data, .cfg_data,
    .supply_ok, .uv_fault_raw, .thermal_shutdown, .addr_pin_fault, .uv_fault, .reset_output_n,
    .reset_output_oe, .interrupt_output_n, .interrupt_output_oe, .watchdog_fault_output_n,
    .watchdog_fault_output_oe, .monitor_status, .selftest_done_status, .selftest_done_flag,
    .selftest_fail_flag, .selftest_info, .soc_error_flag, .esm_fault_flag, .ecc_corrected,
    .i2c_enable, .monitor_enable);
  esr_far_model esr_far_model_i (.core_clk, .rst, .otp_rd, .otp_addr, .otp_valid, .otp_data,
    .selftest_run, .selftest_complete, .selftest_fail, .selftest_result, .cfg_words,
    .err_mode, .slow, .st_bad, .st_res);

  function automatic int ms_of(input logic [7:0] c);
    if (c < 8'h20) return c + 1;
    if (c < 8'h40) return 2 * c - 30;
    return 4 * c - 156;
  endfunction

  // Tick granular timing: one millisecond of skew either way
  function automatic bit in_win(input int v, input logic [7:0] c, input int slack);
    return v >= (ms_of(c) - 1) * TC && v <= (ms_of(c) + 1) * TC + slack;
  endfunction

  task automatic cyc(input int m);
    repeat (m) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    for (n = 0; n < 60 && monitor_status !== m; n++) cyc(1);
  endtask

  task automatic do_reset(input logic strap);
    rst = 1'b1;
    supply_ok = 1'b0;
    selftest_at_poweron = strap;
    {thermal_shutdown, addr_pin_fault} = 2'b00;
    cyc(12);
    `CHK("rst_pins", 2'b11, {reset_output_n, interrupt_output_n})
    `CHK("rst_mode", esr_pkg::MD_OFF, monitor_status)
    rst = 1'b0;
    supply_ok = 1'b1;
    cyc(1);
    `CHK("boot", strap ? esr_pkg::MD_SELFTEST : esr_pkg::MD_LOAD, monitor_status)
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Length of each reset pulse while a routing case is running
  always @(posedge core_clk) begin
    if (reset_output_n === 1'b0) run++;
    else if (run != 0) begin
      if (mon_on) begin
        npulse++;
        `CHK("rst_len", 1'b1, in_win(run, reset_pulse_delay, 2))
      end
      run = 0;
    end
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    {soc_error_input_n, watchdog_enable_pin, wdo_latch_cfg, mon_on} = 4'b1010;
    {error_flag_clr, test_flag_clr, selftest_trigger, uv_fault_raw, st_bad} = 5'h00;
    {esm_map, error_delay_code, reset_pulse_delay} = {3'h0, 8'h02, 8'h01};
    {wdo_delay_code, seq_timeout_code, test_irq_enable} = {8'h01, 8'h07, 2'h1};
    {st_res, err_mode} = {4'h0, 2'h1};
    cfg_words = $random(seed);
    slow = 1'($random(seed));
    do_reset(1'b0);
    uv_fault_raw = 1'b1;
    wait_mode(esr_pkg::MD_ACTIVE);
    `CHK("mode", esr_pkg::MD_ACTIVE, monitor_status)
    `CHK("cfg", cfg_words, cfg_data)
    `CHK("sec", 1'b1, ecc_corrected)
    `CHK("act", 2'b11, {monitor_enable, i2c_enable})
    `CHK("uv_mask", 1'b0, uv_fault)
    cyc(44);
    `CHK("uv_late", 1'b1, uv_fault)
    uv_fault_raw = 1'b0;
    esm_map = 3'h1;
    error_delay_code = 8'h04;
    repeat (5) begin
      soc_error_input_n = 1'b0;
      cyc(8);
      soc_error_input_n = 1'b1;
      cyc(4);
    end
    `CHK("glitch", 1'b1, interrupt_output_n)
    pulse(error_flag_clr);
    foreach (codes[i]) begin
      error_delay_code = codes[i];
      soc_error_input_n = 1'b0;
      for (n = 0; n < 3600 && interrupt_output_n !== 1'b0; n++) cyc(1);
      `CHK("dly", 1'b1, in_win(n, codes[i], 4))
      soc_error_input_n = 1'b1;
      pulse(error_flag_clr);
      cyc(2);
    end
    {esm_map, watchdog_enable_pin, wdo_latch_cfg, error_delay_code} = {3'h4, 2'b10, 8'h00};
    soc_error_input_n = 1'b0;
    for (n = 0; n < 40 && watchdog_fault_output_n !== 1'b0; n++) cyc(1);
    soc_error_input_n = 1'b1;
    cyc(1);
    `CHK("wdo_on", 1'b0, watchdog_fault_output_n)
    cyc(3 * TC + 4);
    `CHK("wdo_off", 1'b1, watchdog_fault_output_n)
    wdo_latch_cfg = 1'b1;
    pulse(error_flag_clr);
    for (k = 0; k < 16; k++) begin
      esm_map = k[2:0];
      watchdog_enable_pin = k[3];
      error_delay_code = 8'($random(seed) & 3);
      reset_pulse_delay = 8'($random(seed) & 3);
      npulse = 0;
      mon_on = 1'b1;
      soc_error_input_n = 1'b0;
      cyc(140);
      `CHK("irq", !esm_map[0], interrupt_output_n)
      `CHK("wdo", !(esm_map[2] && k[3]), watchdog_fault_output_n)
      `CHK("wdo_oe", ~watchdog_fault_output_n, watchdog_fault_output_oe)
      `CHK("vflag", 1'b1, soc_error_flag)
      `CHK("esm_flag", k[0] | (k[2] & k[3]), esm_fault_flag)
      soc_error_input_n = 1'b1;
      cyc(40);
      mon_on = 1'b0;
      `CHK("irq_latch", !esm_map[0], interrupt_output_n)
      `CHK("pulses", k[1] ? ((k[2] & k[3]) ? 1 : 2) : 0, npulse > 2 ? 2 : npulse)
      pulse(error_flag_clr);
      cyc(3);
      `CHK("clr", 2'b11, {interrupt_output_n, watchdog_fault_output_n})
      `CHK("clr_flags", 2'b00, {soc_error_flag, esm_fault_flag})
    end
    st_res = 4'($random(seed));
    esm_map = 3'h1;
    // Host triggers only with every fault output released
    pulse(selftest_trigger);
    `CHK("st_mode", esr_pkg::MD_SELFTEST, monitor_status)
    `CHK("st_run", 2'b10, {selftest_run, i2c_enable})
    soc_error_input_n = 1'b0;
    cyc(5);
    `CHK("st_quiet", 2'b10, {interrupt_output_n, soc_error_flag})
    soc_error_input_n = 1'b1;
    wait_mode(esr_pkg::MD_LOAD);
    `CHK("st_i2c", 1'b1, i2c_enable)
    wait_mode(esr_pkg::MD_ACTIVE);
    cyc(2);
    `CHK("st_done", 2'b11, {selftest_done_flag, selftest_done_status})
    `CHK("st_fail", 1'b0, selftest_fail_flag)
    `CHK("st_info", st_res, selftest_info)
    `CHK("st_irq", 1'b0, interrupt_output_n)
    pulse(test_flag_clr);
    cyc(2);
    `CHK("st_clr", 2'b01, {selftest_done_flag, interrupt_output_n})
    for (k = 0; k < 4; k++) begin
      err_mode = (k == 3) ? 2'h2 : 2'h0;
      st_bad = (k == 2);
      do_reset(k == 2);
      if (k < 2) begin
        wait_mode(esr_pkg::MD_ACTIVE);
        if (k == 0) thermal_shutdown = 1'b1;
        else addr_pin_fault = 1'b1;
        cyc(1);
      end
      wait_mode(esr_pkg::MD_SAFE);
      cyc(2);
      pulse(error_flag_clr);
      pulse(selftest_trigger);
      cyc(20);
      `CHK("safe", esr_pkg::MD_SAFE, monitor_status)
      `CHK("safe_pins", 3'b001, {reset_output_n, interrupt_output_n, i2c_enable})
      `CHK("safe_oe", 2'b11, {reset_output_oe, interrupt_output_oe})
      if (k == 2) `CHK("fail_flag", 1'b1, selftest_fail_flag)
    end
    tally_and_finish;
  end
endmodule
